// >>> bench/pdc_gate_bank_properties.sv
// Concurrent checks on the ports of the gating bank
`timescale 1ns/1ps

module pdc_gate_bank_props (
    input wire        clk_i,
    input wire        rst_i,
    input wire        cyc_i,
    input wire        stb_i,
    input wire [31:0] dat_o,
    input wire        ack_o,
    input wire        instr_clk_en_i,
    input wire        nvm_access_req_i,
    input wire        nvm_ctrl_wr_i,
    input wire        nvm_access_ok_o,
    input wire        nvm_ctrl_wr_ok_o,
    input wire        sysclk_net_off_o,
    input wire        instr_clk_run_o,
    input wire [7:0]  misc_off_o,
    input wire [6:0]  timer_off_o,
    input wire [7:0]  misc_rst_o
);
    // ==========================================================
    // Bus and gate relations
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_one_cycle_a: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    ack_latency_a: assert property (
        cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered in one cycle");
    rdata_idle_a: assert property (
        !ack_o |-> dat_o == 32'h0000_0000)
        else $error("read data not zero outside ack");
    sysclk_bit_a: assert property (
        sysclk_net_off_o == misc_off_o[7])
        else $error("clock network off not bit 7");
    reset_clear_a: assert property (disable iff (1'b0)
        rst_i |=> misc_off_o == 8'h00 && timer_off_o == 7'h00)
        else $error("gates not cleared by reset");
    // Access only granted while the unit is on and was requested
    nvm_access_gate_a: assert property (nvm_access_ok_o |->
        !misc_off_o[2] && $past(nvm_access_req_i))
        else $error("memory access while unit off");
    nvm_ctrl_gate_a: assert property (nvm_ctrl_wr_ok_o |->
        !misc_off_o[2] && $past(nvm_ctrl_wr_i))
        else $error("control write while unit off");
    instr_clk_free_a: assert property (!$past(rst_i) |->
        instr_clk_run_o == $past(instr_clk_en_i))
        else $error("quarter-rate clock disturbed");
    hold_matches_a: assert property (misc_rst_o == misc_off_o)
        else $error("reset hold differs from gate");
endmodule // pdc_gate_bank_props

bind pdc_gate_bank pdc_gate_bank_props u_pdc_gate_bank_props (
    .clk_i            (clk_i),
    .rst_i            (rst_i),
    .cyc_i            (cyc_i),
    .stb_i            (stb_i),
    .dat_o            (dat_o),
    .ack_o            (ack_o),
    .instr_clk_en_i   (instr_clk_en_i),
    .nvm_access_req_i (nvm_access_req_i),
    .nvm_ctrl_wr_i    (nvm_ctrl_wr_i),
    .nvm_access_ok_o  (nvm_access_ok_o),
    .nvm_ctrl_wr_ok_o (nvm_ctrl_wr_ok_o),
    .sysclk_net_off_o (sysclk_net_off_o),
    .instr_clk_run_o  (instr_clk_run_o),
    .misc_off_o       (misc_off_o),
    .timer_off_o      (timer_off_o),
    .misc_rst_o       (misc_rst_o)
);

// >>> bench/tb_top.sv
// Self-checking bench for the peripheral gating bank
`timescale 1ns/1ps

module tb_top;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic        scanner_config_enable_i = 1, zcd_config_force_on_i = 0;
    logic        instr_clk_en_i = 0, nvm_access_req_i = 0, nvm_ctrl_wr_i = 0;
    wire  [31:0] dat_o;
    wire         ack_o, nvm_access_ok_o, nvm_ctrl_wr_ok_o;
    wire         sysclk_net_off_o, instr_clk_run_o;
    wire  [7:0]  misc_off_o, misc_rst_o;
    wire  [6:0]  timer_off_o, timer_rst_o;
    wire  [4:0]  analog_off_o, analog_rst_o;
    wire  [3:0]  pwm_ccp_off_o, pwm_ccp_rst_o;
    wire  [2:0]  serial_off_o, serial_rst_o;
    wire         signal_modulator_off_o, signal_modulator_rst_o;
    int          err_count = 0, checks_done = 0, i;
    logic [31:0] q;
    logic [7:0]  mask [7] = '{8'hFF, 8'h7F, 8'h67, 8'h0F, 8'h51, 8'h01,
                              8'h03};

    pdc_gate_bank u_pdc_gate_bank (
        .clk_i                   (clk_i),
        .rst_i                   (rst_i),
        .cyc_i                   (cyc_i),
        .stb_i                   (stb_i),
        .we_i                    (we_i),
        .adr_i                   (adr_i),
        .sel_i                   (sel_i),
        .dat_i                   (dat_i),
        .dat_o                   (dat_o),
        .ack_o                   (ack_o),
        .scanner_config_enable_i (scanner_config_enable_i),
        .zcd_config_force_on_i   (zcd_config_force_on_i),
        .instr_clk_en_i          (instr_clk_en_i),
        .nvm_access_req_i        (nvm_access_req_i),
        .nvm_ctrl_wr_i           (nvm_ctrl_wr_i),
        .nvm_access_ok_o         (nvm_access_ok_o),
        .nvm_ctrl_wr_ok_o        (nvm_ctrl_wr_ok_o),
        .sysclk_net_off_o        (sysclk_net_off_o),
        .instr_clk_run_o         (instr_clk_run_o),
        .misc_off_o              (misc_off_o),
        .timer_off_o             (timer_off_o),
        .analog_off_o            (analog_off_o),
        .pwm_ccp_off_o           (pwm_ccp_off_o),
        .serial_off_o            (serial_off_o),
        .signal_modulator_off_o  (signal_modulator_off_o),
        .misc_rst_o              (misc_rst_o),
        .timer_rst_o             (timer_rst_o),
        .analog_rst_o            (analog_rst_o),
        .pwm_ccp_rst_o           (pwm_ccp_rst_o),
        .serial_rst_o            (serial_rst_o),
        .signal_modulator_rst_o  (signal_modulator_rst_o)
    );

    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) instr_clk_en_i <= ~instr_clk_en_i;

    // ==========================================================
    // Tasks
    task chk(input string n, input [31:0] s, input [31:0] e);
        checks_done++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask

    // One classic cycle; hangs are cut by the watchdog
    task xfer(input w, input [7:0] a, input [7:0] d, input s,
              output [31:0] r);
        @(posedge clk_i);
        cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a;
        dat_i <= {24'h0, d}; sel_i <= {3'h0, s};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        r = dat_o;
        cyc_i <= 0; stb_i <= 0; we_i <= 0;
    endtask

    task settle;
        repeat (2) @(posedge clk_i);
        #1;
    endtask

    task tally_and_finish;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #10000;
        err_count++;
        tally_and_finish;
    end

    // ==========================================================
    // Tests
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        for (i = 0; i < 7; i++) begin
            xfer(0, 8'(4 * i), 0, 1, q);
            chk("reset value", q, 0);
        end
        nvm_access_req_i <= 1;
        nvm_ctrl_wr_i <= 1;
        for (i = 0; i < 7; i++) begin
            xfer(1, 8'(4 * i), 8'hFF, 1, q);
            xfer(0, 8'(4 * i), 0, 1, q);
            chk("readback", q, mask[i]);
        end
        settle;
        chk("gates", {misc_off_o, timer_off_o, analog_off_o, pwm_ccp_off_o,
            serial_off_o, signal_modulator_off_o}, 28'hFFFFFFF);
        chk("holds", {misc_rst_o, timer_rst_o, analog_rst_o, pwm_ccp_rst_o,
            serial_rst_o, signal_modulator_rst_o}, 28'hFFFFFFF);
        chk("clock net", sysclk_net_off_o, 1);
        chk("nvm blocked", {nvm_access_ok_o, nvm_ctrl_wr_ok_o}, 0);
        @(posedge clk_i);
        scanner_config_enable_i <= 0;
        zcd_config_force_on_i <= 1;
        settle;
        chk("scanner", misc_off_o[3], 0);
        chk("zero cross", analog_off_o[0], 0);
        xfer(1, 8'h00, 8'h00, 0, q);
        xfer(0, 8'h00, 0, 1, q);
        chk("no lane", q, 8'hFF);
        xfer(1, 8'h20, 8'hFF, 1, q);
        xfer(0, 8'h20, 0, 1, q);
        chk("unmapped", q, 0);
        xfer(1, 8'h00, 8'h00, 1, q);
        settle;
        chk("ctrl wr", nvm_ctrl_wr_ok_o, 1);
        chk("waking", nvm_access_ok_o, 0);
        chk("clock net on", sysclk_net_off_o, 0);
        // Wake ends 201 cycles after the clearing write edge
        repeat (197) @(posedge clk_i);
        #1;
        chk("still waking", nvm_access_ok_o, 0);
        @(posedge clk_i);
        #1;
        chk("awake", nvm_access_ok_o, 1);
        xfer(0, 8'h1C, 0, 1, q);
        chk("status", q[0], 1);
        xfer(1, 8'h04, 8'h00, 1, q);
        settle;
        chk("timer on", {timer_off_o, timer_rst_o}, 0);
        xfer(1, 8'h00, 8'hFF, 1, q);
        @(posedge clk_i);
        rst_i <= 1;
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        settle;
        chk("mid reset", {misc_off_o, analog_off_o, serial_off_o}, 0);
        tally_and_finish;
    end
endmodule // tb_top

// >>> common/pdc_defines.vh
// Register map, field positions and timing constants of the gating bank
`ifndef PDC_DEFINES_VH
`define PDC_DEFINES_VH

// ==========================================================
// Register word offsets (byte addresses)
`define PDC_OFS_MISC      8'h00
`define PDC_OFS_TIMER     8'h04
`define PDC_OFS_ANALOG    8'h08
`define PDC_OFS_PWMCCP    8'h0C
`define PDC_OFS_SERIAL    8'h10
`define PDC_OFS_MODUL     8'h14
`define PDC_OFS_CONFIG    8'h18
`define PDC_OFS_STATUS    8'h1C

// ==========================================================
// Writable-bit masks; unimplemented positions are zero
`define PDC_MASK_MISC     8'hFF
`define PDC_MASK_TIMER    8'h7F
`define PDC_MASK_ANALOG   8'h67
`define PDC_MASK_PWMCCP   8'h0F
`define PDC_MASK_SERIAL   8'h51
`define PDC_MASK_MODUL    8'h01
`define PDC_MASK_CONFIG   8'h03
`define PDC_RESET_VAL     8'h00

// ==========================================================
// Field positions, misc register
`define PDC_B_SYSCLK      7
`define PDC_B_VREF        6
`define PDC_B_VDET        5
`define PDC_B_CRC         4
`define PDC_B_SCAN        3
`define PDC_B_NVM         2
`define PDC_B_CLKREF      1
`define PDC_B_PINCHG      0
// Analog register
`define PDC_B_DAC         6
`define PDC_B_ADC         5
`define PDC_B_CMP2        2
`define PDC_B_CMP1        1
`define PDC_B_ZCD         0
// Pwm/ccp register
`define PDC_B_PWM4        3
`define PDC_B_PWM3        2
`define PDC_B_CCP2        1
`define PDC_B_CCP1        0
// Serial register
`define PDC_B_UART        6
`define PDC_B_SSP         4
`define PDC_B_CWG         0
// Modulator register
`define PDC_B_DSM         0
// Config register: scanner enable, zero-cross override; status register: memory ready
`define PDC_B_CFG_SCAN    0
`define PDC_B_CFG_ZCD     1
`define PDC_B_ST_NVMRDY   0

// ==========================================================
// Timing: nonvolatile unit wake time after re-enable
`define PDC_CLK_MHZ       200
`define PDC_NVM_WAKE_NS   1000
// 1000 ns at 200 MHz, sized to the wake counter
`define PDC_NVM_WAKE_CYC  8'hC8
`define PDC_WAKE_W        8
`define PDC_RD_ZERO       32'h0000_0000

`endif

// >>> core/pdc_gate_bank.v
// Peripheral disable bank with classic Wishbone register access
//
// Notes on behaviour
// RULE1 - One written means peripheral disabled
// RULE2 - Bit 7 first register stops fast clock
// RULE3 - Quarter-rate clocked peripherals stay running
// RULE4 - Memory unit off blocks access, control writes
// RULE5 - Software waits 1 us after memory re-enable
// RULE6 - First register: sysclk down to pin-change
// RULE7 - Second register: timers 0..6, bit 7 none
// RULE8 - Third: dac, adc, cmp2, cmp1, zero-cross
// RULE9 - Fourth: pwm4, pwm3, capture2, capture1
// RULE10 - Fifth: uart 6, sync serial 4, waveform 0
// RULE11 - Sixth: only modulator bit 0
// RULE12 - Unimplemented bits read zero, ignore writes
// RULE13 - Scanner bit gated by config enable
// RULE14 - Zero-cross config may override software
// RULE15 - Any reset clears every gating bit
// RULE16 - Disabled unit: no clock, held reset
// RULE17 - Re-enabled unit restarts at power-on state
// RULE18 - Software waits one instruction after enable
// RULE19 - Each bit is a registered level output
`timescale 1ns/1ps
`include "pdc_defines.vh"

module pdc_gate_bank (
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [7:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // Configuration word settings
    input  wire        scanner_config_enable_i,
    input  wire        zcd_config_force_on_i,
    // Instruction-clock phase for quarter-rate peripherals
    input  wire        instr_clk_en_i,
    // Nonvolatile unit requests
    input  wire        nvm_access_req_i,
    input  wire        nvm_ctrl_wr_i,
    output reg         nvm_access_ok_o,
    output reg         nvm_ctrl_wr_ok_o,
    // Clock network
    output reg         sysclk_net_off_o,
    output reg         instr_clk_run_o,
    // Per-peripheral gate levels
    output wire [7:0]  misc_off_o,
    output wire [6:0]  timer_off_o,
    output wire [4:0]  analog_off_o,
    output wire [3:0]  pwm_ccp_off_o,
    output wire [2:0]  serial_off_o,
    output wire        signal_modulator_off_o,
    // Matching reset holds
    output wire [7:0]  misc_rst_o,
    output wire [6:0]  timer_rst_o,
    output wire [4:0]  analog_rst_o,
    output wire [3:0]  pwm_ccp_rst_o,
    output wire [2:0]  serial_rst_o,
    output wire        signal_modulator_rst_o
);

// ==========================================================
// Register storage
reg  [7:0] misc_module_gate_q;
reg  [7:0] timer_module_gate_q;
reg  [7:0] analog_module_gate_q;
reg  [7:0] pwm_ccp_module_gate_q;
reg  [7:0] serial_module_gate_q;
reg  [7:0] modulator_module_gate_q;
reg  [7:0] config_q;
reg  [`PDC_WAKE_W-1:0] nvm_wake_q;

wire       req_w;
wire       wr_w;
wire       lane0_w;
reg  [31:0] rd_d;

assign req_w   = cyc_i & stb_i & ~ack_o;
assign wr_w    = req_w & we_i;
assign lane0_w = sel_i[0];

// ==========================================================
// Register writes; masks drop unimplemented positions
always @(posedge clk_i) begin
    if (rst_i) begin
        misc_module_gate_q      <= `PDC_RESET_VAL; // RULE15
        timer_module_gate_q     <= `PDC_RESET_VAL;
        analog_module_gate_q    <= `PDC_RESET_VAL;
        pwm_ccp_module_gate_q   <= `PDC_RESET_VAL;
        serial_module_gate_q    <= `PDC_RESET_VAL;
        modulator_module_gate_q <= `PDC_RESET_VAL;
        config_q                <= `PDC_RESET_VAL;
    end else if (wr_w && lane0_w) begin
        if (adr_i == `PDC_OFS_MISC) begin
            misc_module_gate_q <= dat_i[7:0] & `PDC_MASK_MISC; // RULE6
        end else if (adr_i == `PDC_OFS_TIMER) begin
            timer_module_gate_q <= dat_i[7:0] & `PDC_MASK_TIMER; // RULE7
        end else if (adr_i == `PDC_OFS_ANALOG) begin
            analog_module_gate_q <= dat_i[7:0] & `PDC_MASK_ANALOG; // RULE8
        end else if (adr_i == `PDC_OFS_PWMCCP) begin
            pwm_ccp_module_gate_q <= dat_i[7:0] & `PDC_MASK_PWMCCP; // RULE9
        end else if (adr_i == `PDC_OFS_SERIAL) begin
            serial_module_gate_q <= dat_i[7:0] & `PDC_MASK_SERIAL; // RULE10
        end else if (adr_i == `PDC_OFS_MODUL) begin
            modulator_module_gate_q <= dat_i[7:0] & `PDC_MASK_MODUL; // RULE11
        end else if (adr_i == `PDC_OFS_CONFIG) begin
            config_q <= dat_i[7:0] & `PDC_MASK_CONFIG;
        end
    end
end

// ==========================================================
// Read mux; unmapped addresses read zero and still ack
always @* begin
    rd_d = `PDC_RD_ZERO;
    if (adr_i == `PDC_OFS_MISC) begin
        rd_d[7:0] = misc_module_gate_q;
    end else if (adr_i == `PDC_OFS_TIMER) begin
        rd_d[7:0] = timer_module_gate_q; // RULE12
    end else if (adr_i == `PDC_OFS_ANALOG) begin
        rd_d[7:0] = analog_module_gate_q;
    end else if (adr_i == `PDC_OFS_PWMCCP) begin
        rd_d[7:0] = pwm_ccp_module_gate_q;
    end else if (adr_i == `PDC_OFS_SERIAL) begin
        rd_d[7:0] = serial_module_gate_q;
    end else if (adr_i == `PDC_OFS_MODUL) begin
        rd_d[7:0] = modulator_module_gate_q;
    end else if (adr_i == `PDC_OFS_CONFIG) begin
        rd_d[7:0] = config_q;
    end else if (adr_i == `PDC_OFS_STATUS) begin
        rd_d[`PDC_B_ST_NVMRDY] = nvm_access_ok_o;
    end
end

always @(posedge clk_i) begin
    if (rst_i) begin
        ack_o <= 1'b0;
        dat_o <= `PDC_RD_ZERO;
    end else begin
        ack_o <= req_w;
        dat_o <= req_w ? rd_d : `PDC_RD_ZERO;
    end
end

// ==========================================================
// Effective gate levels after configuration overrides
wire [7:0] misc_eff_w;
wire [4:0] analog_eff_w;
wire [2:0] serial_eff_w;
wire [3:0] pwm_eff_w;

assign misc_eff_w = {
    misc_module_gate_q[`PDC_B_SYSCLK],
    misc_module_gate_q[`PDC_B_VREF],
    misc_module_gate_q[`PDC_B_VDET],
    misc_module_gate_q[`PDC_B_CRC],
    // Scanner can only be switched off when config allows it
    misc_module_gate_q[`PDC_B_SCAN] & scanner_config_enable_i, // RULE13
    misc_module_gate_q[`PDC_B_NVM],
    misc_module_gate_q[`PDC_B_CLKREF],
    misc_module_gate_q[`PDC_B_PINCHG]
};

assign analog_eff_w = {
    analog_module_gate_q[`PDC_B_DAC],
    analog_module_gate_q[`PDC_B_ADC],
    analog_module_gate_q[`PDC_B_CMP2],
    analog_module_gate_q[`PDC_B_CMP1],
    // Config forcing the detector on beats software
    analog_module_gate_q[`PDC_B_ZCD] & ~zcd_config_force_on_i // RULE14
};

assign pwm_eff_w = {
    pwm_ccp_module_gate_q[`PDC_B_PWM4],
    pwm_ccp_module_gate_q[`PDC_B_PWM3],
    pwm_ccp_module_gate_q[`PDC_B_CCP2],
    pwm_ccp_module_gate_q[`PDC_B_CCP1]
};

assign serial_eff_w = {
    serial_module_gate_q[`PDC_B_UART],
    serial_module_gate_q[`PDC_B_SSP],
    serial_module_gate_q[`PDC_B_CWG]
};

// ==========================================================
// Gate cells, one per peripheral
wire [27:0] gate_in_w;
wire [27:0] gate_off_w;
wire [27:0] gate_rst_w;

assign gate_in_w = {
    modulator_module_gate_q[`PDC_B_DSM],
    serial_eff_w,
    pwm_eff_w,
    analog_eff_w,
    timer_module_gate_q[6:0],
    misc_eff_w
};

genvar gi;
generate
    for (gi = 0; gi < 28; gi = gi + 1) begin : g_cell
        pdc_gate_cell u_cell (
            .clk_i      (clk_i),
            .rst_i      (rst_i),
            .off_i      (gate_in_w[gi]), // RULE1
            .off_o      (gate_off_w[gi]),
            .hold_rst_o (gate_rst_w[gi])
        );
    end
endgenerate

assign misc_off_o             = gate_off_w[7:0];
assign timer_off_o            = gate_off_w[14:8];
assign analog_off_o           = gate_off_w[19:15];
assign pwm_ccp_off_o          = gate_off_w[23:20];
assign serial_off_o           = gate_off_w[26:24];
assign signal_modulator_off_o = gate_off_w[27];
assign misc_rst_o             = gate_rst_w[7:0];
assign timer_rst_o            = gate_rst_w[14:8];
assign analog_rst_o           = gate_rst_w[19:15];
assign pwm_ccp_rst_o          = gate_rst_w[23:20];
assign serial_rst_o           = gate_rst_w[26:24];
assign signal_modulator_rst_o = gate_rst_w[27];

// ==========================================================
// Clock network gating
always @(posedge clk_i) begin
    if (rst_i) begin
        sysclk_net_off_o <= 1'b0;
        instr_clk_run_o  <= 1'b0;
    end else begin
        sysclk_net_off_o <= misc_module_gate_q[`PDC_B_SYSCLK]; // RULE2
        // Quarter-rate enable ignores the fast network gate
        instr_clk_run_o  <= instr_clk_en_i; // RULE3
    end
end

// ==========================================================
// Nonvolatile unit: block while off, wake delay after enable
wire nvm_off_w;
assign nvm_off_w = misc_module_gate_q[`PDC_B_NVM];

always @(posedge clk_i) begin
    if (rst_i) begin
        nvm_wake_q <= `PDC_NVM_WAKE_CYC;
    end else if (nvm_off_w) begin
        nvm_wake_q <= `PDC_NVM_WAKE_CYC;
    end else if (nvm_wake_q != {`PDC_WAKE_W{1'b0}}) begin
        // Hardware covers the software wait for access only; control writes are not delayed
        nvm_wake_q <= nvm_wake_q - 1'b1; // RULE5
    end
end

always @(posedge clk_i) begin
    if (rst_i) begin
        nvm_access_ok_o  <= 1'b0;
        nvm_ctrl_wr_ok_o <= 1'b0;
    end else begin
        nvm_access_ok_o  <= nvm_access_req_i & ~nvm_off_w
                            & (nvm_wake_q == {`PDC_WAKE_W{1'b0}}); // RULE4
        nvm_ctrl_wr_ok_o <= nvm_ctrl_wr_i & ~nvm_off_w; // RULE4
    end
end

endmodule // pdc_gate_bank

// >>> core/pdc_gate_cell.v
// One peripheral gating cell: registered off level and reset hold
`timescale 1ns/1ps

module pdc_gate_cell (
    input  wire clk_i,
    input  wire rst_i,
    input  wire off_i,
    output reg  off_o,
    output reg  hold_rst_o
);

// ==========================================================
// Registered gate level
always @(posedge clk_i) begin
    if (rst_i) begin
        off_o      <= 1'b0; // RULE15
        hold_rst_o <= 1'b0;
    end else begin
        off_o      <= off_i; // RULE19
        // Hold in reset while off; release re-enters power-on state
        hold_rst_o <= off_i; // RULE16 RULE17
    end
end

endmodule // pdc_gate_cell
